// File: verilog/lpmc_ctrl.sv
// Power mode sequencer: regulators, clocks, retention, wake and reset-time pin control
`timescale 1ns/1ps

module lpmc_ctrl #(
    parameter int LP_DIV = lpmc_pkg::LP_DIV,                  // Core cycles per capped cpu tick
    parameter int WAKE_RST_CYCLES = lpmc_pkg::WAKE_RST_CYCLES // Reboot pulse length
) (
    input wire logic core_clk_in,                        // Core clock, 250 MHz
    input wire logic reset_in,                           // System reset, active high
    input wire logic supply_good_in,                     // Supply monitor says supply is good
    input wire lpmc_pkg::lpmc_sel_e mode_sel_in,         // Software mode selection
    input wire logic mode_req_in,                        // Software asks to apply mode_sel_in
    input wire logic cpu_halted_in,                      // Processor has halted
    input wire logic irq_in,                             // Any interrupt or event
    input wire logic periph_wake_in,                     // Wake request from a peripheral
    input wire logic periph_osc_req_in,                  // Peripheral wants the fast oscillator
    input wire logic rtc_keep_in,                        // Keep RTC running in Stop/Standby
    input wire lpmc_pkg::lpmc_wake_s standby_wake_in,    // Standby exit sources
    input wire logic wake_pin_in,                        // Wake pin level
    input wire logic wake_pin_fall_in,                   // Wake pin edge: 1 falling, 0 rising
    input wire logic internal_reset_src_in,              // Current reset source is internal
    input wire logic [lpmc_pkg::PULL_W-1:0] pull_cfg_in, // Per-I/O pull choice
    input wire logic main_supply_valid_in,               // Main supply in valid range
    input wire logic backup_supply_valid_in,             // Backup pin supply valid
    input wire logic charge_req_in,                      // Software asks for battery charging
    output lpmc_pkg::lpmc_mode_e mode_out,               // Current power mode
    output lpmc_pkg::lpmc_pwr_s pwr_out,                 // Regulator, oscillator, clock controls
    output logic cpu_clk_en_out,                         // Processor clock enable
    output logic sys_reset_out,                          // Device-wide reset, active high
    output logic schmitt_en_out,                         // I/O input Schmitt trigger enable
    output logic reset_pin_pullup_en_out,                // Reset pin pull-up enable
    output logic [lpmc_pkg::PULL_W-1:0] pull_out,        // Pull choice applied to the I/Os
    output logic backup_from_main_out,                   // Backup domain fed from main supply
    output logic charge_en_out                           // Battery charger enable
);
    localparam int CW = $clog2(WAKE_RST_CYCLES + 1);

    if (LP_DIV < 1) begin : g_chk_div
        $error("lpmc_ctrl: LP_DIV must be at least 1");
    end
    if (WAKE_RST_CYCLES < 1 || CW > lpmc_pkg::CNT_W) begin : g_chk_rst
        $error("lpmc_ctrl: WAKE_RST_CYCLES does not fit the reboot counter");
    end

    // Whole module state
    typedef struct packed {
        lpmc_pkg::lpmc_mode_e mode;
        logic ret_lp;
        logic pend;
        logic [lpmc_pkg::CNT_W-1:0] cnt;
        logic sys_rst;
        logic schmitt_en;
        logic pullup_en;
        logic cpu_clk_en;
        logic bkp_main;
        logic charge_en;
        logic [lpmc_pkg::PULL_W-1:0] pull;
        lpmc_pkg::lpmc_pwr_s pwr;
    } lpmc_state_s;

    // Supply and clock controls for each mode
    function automatic lpmc_pkg::lpmc_pwr_s pwr_for(
        input lpmc_pkg::lpmc_mode_e m,
        input logic rtc_keep,
        input logic osc_req
    );
        lpmc_pkg::lpmc_pwr_s p;
        p = '0;
        p.slow_oscillator_en = 1'b1;
        p.rtc_en = 1'b1;
        p.retain = 1'b1;
        p.core_supply_domain_on = 1'b1;
        unique case (m)
            lpmc_pkg::M_RUN, lpmc_pkg::M_SLEEP, lpmc_pkg::M_REBOOT: begin
                // Full-power modes run from the main regulator
                p.main_regulator_en = 1'b1;
                p.core_clk_en = 1'b1;
                p.pll_en = 1'b1;
                p.internal_fast_oscillator_en = 1'b1;
                p.external_fast_oscillator_en = 1'b1;
            end
            lpmc_pkg::M_LPRUN, lpmc_pkg::M_LPSLEEP: begin
                // Peripherals with their own clock may still use the internal fast oscillator
                p.low_power_regulator_en = 1'b1;
                p.core_clk_en = 1'b1;
                p.internal_fast_oscillator_en = 1'b1;
            end
            lpmc_pkg::M_STOP0, lpmc_pkg::M_STOP1: begin
                // Core clocks gated; slow oscillator left free, internal fast oscillator only on peripheral request
                p.low_power_regulator_en = 1'b1;
                p.main_regulator_en = (m == lpmc_pkg::M_STOP0);
                p.internal_fast_oscillator_en = osc_req;
                p.rtc_en = rtc_keep;
            end
            lpmc_pkg::M_STANDBY: begin
                // Everything but the standby circuitry goes dark
                p.main_regulator_hiz = 1'b1;
                p.low_power_regulator_hiz = 1'b1;
                p.core_supply_domain_on = 1'b0;
                p.retain = 1'b0;
                p.rtc_en = rtc_keep;
            end
        endcase
        return p;
    endfunction

    localparam lpmc_state_s ST_RST = '{
        mode: lpmc_pkg::M_RUN,
        ret_lp: 1'b0,
        pend: 1'b0,
        cnt: lpmc_pkg::CNT_RST,
        sys_rst: 1'b1,
        schmitt_en: 1'b0,
        pullup_en: 1'b1,
        cpu_clk_en: 1'b0,
        bkp_main: 1'b0,
        charge_en: 1'b0,
        pull: lpmc_pkg::PULL_RST,
        pwr: pwr_for(lpmc_pkg::M_RUN, 1'b0, 1'b0)
    };

    lpmc_state_s q;
    lpmc_state_s d;
    logic lp_tick;
    logic pin_edge;
    logic hard_rst;
    logic halt_ok;
    logic stop_wake;
    logic stby_wake;

    // Capped processor clock for low-power run
    lpmc_div #(
        .DIV(LP_DIV)
    ) u_div (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .run_in(q.mode == lpmc_pkg::M_LPRUN),
        .tick_out(lp_tick)
    );

    // Wake pin edge, polarity chosen by software
    lpmc_edge u_edge (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .sig_in(wake_pin_in),
        .fall_sel_in(wake_pin_fall_in),
        .edge_out(pin_edge)
    );

    // Wake qualification; with no valid main supply the device is on backup power
    // and no interrupt or RTC event may wake it from Stop or Standby
    always_comb begin
        hard_rst = reset_in | ~supply_good_in;
        halt_ok = mode_req_in & cpu_halted_in;
        stop_wake = (irq_in | periph_wake_in | q.pend) & main_supply_valid_in;
        stby_wake = main_supply_valid_in & (pin_edge
            | standby_wake_in.external_reset_pin
            | standby_wake_in.independent_watchdog
            | standby_wake_in.clock_failure_detector
            | (rtc_keep_in & (standby_wake_in.rtc_alarm
            | standby_wake_in.rtc_periodic
            | standby_wake_in.tamper_unit)));
    end

    // Next-state logic
    always_comb begin
        d = q;
        d.pend = 1'b0;
        unique case (q.mode)
            lpmc_pkg::M_RUN, lpmc_pkg::M_LPRUN: begin
                // Leaving a run mode happens only on a software request
                if (mode_req_in) begin
                    d.ret_lp = (q.mode == lpmc_pkg::M_LPRUN);
                    unique case (mode_sel_in)
                        lpmc_pkg::SEL_RUN: d.mode = lpmc_pkg::M_RUN;
                        lpmc_pkg::SEL_LPRUN: d.mode = lpmc_pkg::M_LPRUN;
                        lpmc_pkg::SEL_SLEEP: begin
                            if (halt_ok) begin
                                d.mode = (q.mode == lpmc_pkg::M_LPRUN) ?
                                    lpmc_pkg::M_LPSLEEP : lpmc_pkg::M_SLEEP;
                            end
                        end
                        lpmc_pkg::SEL_STOP0: begin
                            if (halt_ok) begin
                                d.mode = lpmc_pkg::M_STOP0;
                            end
                        end
                        lpmc_pkg::SEL_STOP1: begin
                            if (halt_ok) begin
                                d.mode = lpmc_pkg::M_STOP1;
                            end
                        end
                        lpmc_pkg::SEL_STANDBY: begin
                            if (halt_ok) begin
                                d.mode = lpmc_pkg::M_STANDBY;
                            end
                        end
                        default: d.mode = q.mode;
                    endcase
                    // A wake arriving in the entry cycle is kept and ends Sleep or Stop at once; Standby ignores it
                    d.pend = halt_ok & (irq_in | periph_wake_in);
                end
            end
            lpmc_pkg::M_SLEEP: begin
                if (irq_in | q.pend) begin
                    d.mode = lpmc_pkg::M_RUN;
                end
            end
            lpmc_pkg::M_LPSLEEP: begin
                if (irq_in | q.pend) begin
                    d.mode = lpmc_pkg::M_LPRUN;
                end
            end
            lpmc_pkg::M_STOP0, lpmc_pkg::M_STOP1: begin
                // Back to the run mode held before entry, with retained state
                if (stop_wake) begin
                    d.mode = q.ret_lp ? lpmc_pkg::M_LPRUN : lpmc_pkg::M_RUN;
                end
            end
            lpmc_pkg::M_STANDBY: begin
                // Exit from standby is a restart, so it passes through a reset pulse
                if (stby_wake) begin
                    d.mode = lpmc_pkg::M_REBOOT;
                    d.cnt = lpmc_pkg::CNT_RST;
                end
            end
            lpmc_pkg::M_REBOOT: begin
                if (q.cnt == lpmc_pkg::CNT_W'(WAKE_RST_CYCLES - 1)) begin
                    d.mode = lpmc_pkg::M_RUN;
                    d.ret_lp = 1'b0;
                    d.cnt = lpmc_pkg::CNT_RST;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            default: d.mode = lpmc_pkg::M_RUN;
        endcase

        d.pwr = pwr_for(d.mode, rtc_keep_in, periph_osc_req_in);

        // Processor clock: free in Run, one tick per divide period in low-power run
        unique case (d.mode)
            lpmc_pkg::M_RUN: d.cpu_clk_en = 1'b1;
            lpmc_pkg::M_LPRUN: d.cpu_clk_en = lp_tick;
            default: d.cpu_clk_en = 1'b0;
        endcase

        // Pull choice follows software, frozen from standby entry until exit
        d.pull = (q.mode == lpmc_pkg::M_STANDBY) ? q.pull : pull_cfg_in;

        // Backup domain supply switch and charger
        d.bkp_main = main_supply_valid_in & backup_supply_valid_in;
        d.charge_en = charge_req_in & main_supply_valid_in;

        // Supply failure overrides every mode
        if (hard_rst) begin
            d = ST_RST;
            d.pull = pull_cfg_in;
            d.bkp_main = main_supply_valid_in & backup_supply_valid_in;
            d.charge_en = charge_req_in & main_supply_valid_in;
        end

        // Reset-time pin behaviour
        d.sys_rst = hard_rst | (d.mode == lpmc_pkg::M_REBOOT);
        // Enable only after one full cycle out of reset, so the release edge is covered
        d.schmitt_en = ~d.sys_rst & ~q.sys_rst;
        // Pull-up is dropped while an internal source holds the device in reset, except under reset_in, which loads ST_RST with it on
        d.pullup_en = ~(d.sys_rst & (internal_reset_src_in | ~supply_good_in
            | (d.mode == lpmc_pkg::M_REBOOT)
            & ~standby_wake_in.external_reset_pin));
    end

    // State register; a supply-failure reset needs no clean clock beyond this domain
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state register
    always_comb begin
        mode_out = q.mode;
        pwr_out = q.pwr;
        cpu_clk_en_out = q.cpu_clk_en;
        sys_reset_out = q.sys_rst;
        schmitt_en_out = q.schmitt_en;
        reset_pin_pullup_en_out = q.pullup_en;
        pull_out = q.pull;
        backup_from_main_out = q.bkp_main;
        charge_en_out = q.charge_en;
    end
endmodule

// File: verilog/lpmc_pkg.sv
// Shared constants and types of the low-power mode controller
package lpmc_pkg;

    // Core clock rate and the processor clock ceiling in low-power run
    localparam int CLK_HZ = 250_000_000;
    localparam int CPU_LP_MAX_HZ = 2_000_000;
    // Divide ratio rounds up so the capped rate never exceeds the ceiling
    localparam int LP_DIV = (CLK_HZ + CPU_LP_MAX_HZ - 1) / CPU_LP_MAX_HZ;

    // Length of the internal reset pulse that restarts the device after standby
    localparam int WAKE_RST_CYCLES = 8;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

    // Number of I/Os whose resistor choice is held through standby, two bits each
    localparam int IO_COUNT = 16;
    localparam int PULL_W = 2 * IO_COUNT;
    localparam logic [PULL_W-1:0] PULL_RST = 32'h0000_0000;

    // Software mode selection field
    typedef enum logic [2:0] {
        SEL_RUN,
        SEL_SLEEP,
        SEL_LPRUN,
        SEL_STOP0,
        SEL_STOP1,
        SEL_STANDBY
    } lpmc_sel_e;

    // Power mode state
    typedef enum logic [2:0] {
        M_RUN,
        M_SLEEP,
        M_LPRUN,
        M_LPSLEEP,
        M_STOP0,
        M_STOP1,
        M_STANDBY,
        M_REBOOT
    } lpmc_mode_e;

    // Supply, oscillator and retention controls driven towards the analog side
    typedef struct packed {
        logic main_regulator_en;
        logic main_regulator_hiz;
        logic low_power_regulator_en;
        logic low_power_regulator_hiz;
        logic core_supply_domain_on;
        logic core_clk_en;
        logic pll_en;
        logic internal_fast_oscillator_en;
        logic external_fast_oscillator_en;
        logic slow_oscillator_en;
        logic rtc_en;
        logic retain;
    } lpmc_pwr_s;

    // Sources that may end standby
    typedef struct packed {
        logic external_reset_pin;
        logic independent_watchdog;
        logic rtc_alarm;
        logic rtc_periodic;
        logic tamper_unit;
        logic clock_failure_detector;
    } lpmc_wake_s;

endpackage

// File: verilog/lpmc_div.sv
// Enable pulse divider for the capped processor clock
`timescale 1ns/1ps
module lpmc_div #(
    parameter int DIV = lpmc_pkg::LP_DIV
) (
    input wire logic core_clk_in, // Core clock
    input wire logic reset_in,    // Synchronous reset, active high
    input wire logic run_in,      // Count only while set
    output logic tick_out         // One-cycle pulse every DIV cycles
);
    localparam int CW = $clog2(DIV + 1);

    if (DIV < 1) begin : g_chk
        $error("lpmc_div: DIV must be at least 1");
    end

    logic [CW-1:0] cnt_q;

    // Restart from zero whenever counting stops so the first pulse is a full period away
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !run_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_out <= 1'b0;
        end
    end
endmodule

// File: verilog/lpmc_edge.sv
// Selectable rising or falling edge detector for the wake pin
`timescale 1ns/1ps
module lpmc_edge (
    input wire logic core_clk_in, // Core clock
    input wire logic reset_in,    // Synchronous reset, active high
    input wire logic sig_in,      // Level to watch
    input wire logic fall_sel_in, // 1 selects falling edge, 0 rising
    output logic edge_out         // One-cycle pulse on the chosen edge
);
    logic prev_q;

    // Previous level loads the live pin during reset, so a pin already high gives no false edge
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            prev_q <= sig_in;
            edge_out <= 1'b0;
        end else begin
            prev_q <= sig_in;
            edge_out <= fall_sel_in ? (prev_q & ~sig_in) : (~prev_q & sig_in);
        end
    end
endmodule

// File: dv/lpmc_ctrl_props.sv
// Port-level assertions for the power mode sequencer
`timescale 1ns/1ps
module lpmc_ctrl_props #(
    parameter int LP_DIV = lpmc_pkg::LP_DIV // Core cycles per capped cpu tick
) (
    input wire logic core_clk_in, // Core clock
    input wire logic reset_in, // Sync reset
    input wire logic supply_good_in, // Supply good
    input wire logic periph_osc_req_in, // Oscillator request
    input wire logic main_supply_valid_in, // Main supply valid
    input wire logic backup_supply_valid_in, // Backup supply valid
    input wire lpmc_pkg::lpmc_mode_e mode_out, // Current mode
    input wire lpmc_pkg::lpmc_pwr_s pwr_out, // Power controls
    input wire logic cpu_clk_en_out, // Cpu clock enable
    input wire logic sys_reset_out, // Device reset
    input wire logic schmitt_en_out, // Schmitt enable
    input wire logic [lpmc_pkg::PULL_W-1:0] pull_out, // Applied pulls
    input wire logic backup_from_main_out, // Backup domain source
    input wire logic charge_en_out // Charger enable
);
    // Mode decodes shared by several checks
    logic stop_w;
    logic sb_w;
    assign stop_w = mode_out inside {lpmc_pkg::M_STOP0, lpmc_pkg::M_STOP1};
    assign sb_w = mode_out == lpmc_pkg::M_STANDBY;
    // Tick spacing; seen_q keeps the first tick after entry from being judged
    int gap_q;
    logic seen_q;
    always_ff @(posedge core_clk_in) begin
        gap_q <= cpu_clk_en_out ? 0 : gap_q + 1;
        seen_q <= !reset_in && mode_out == lpmc_pkg::M_LPRUN && (seen_q || cpu_clk_en_out);
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    a_supply_hold: assert property (!supply_good_in |=> sys_reset_out)
        else $error("device reset not held on bad supply");
    a_standby_off: assert property (sb_w |-> pwr_out.main_regulator_hiz &&
        pwr_out.low_power_regulator_hiz && !pwr_out.main_regulator_en &&
        !pwr_out.low_power_regulator_en && !pwr_out.core_supply_domain_on && !pwr_out.pll_en &&
        !pwr_out.internal_fast_oscillator_en && !pwr_out.external_fast_oscillator_en)
        else $error("standby power controls wrong");
    a_stop_gates: assert property (stop_w |-> !pwr_out.core_clk_en && !pwr_out.pll_en &&
        !pwr_out.external_fast_oscillator_en && pwr_out.slow_oscillator_en && pwr_out.retain &&
        !cpu_clk_en_out) else $error("stop clock gating wrong");
    a_stop_main: assert property (stop_w |->
        pwr_out.main_regulator_en == (mode_out == lpmc_pkg::M_STOP0))
        else $error("main regulator wrong in stop");
    a_osc_req: assert property (stop_w && $stable(mode_out) |->
        pwr_out.internal_fast_oscillator_en == $past(periph_osc_req_in))
        else $error("fast oscillator request not honoured");
    a_lp_cap: assert property (mode_out == lpmc_pkg::M_LPRUN && cpu_clk_en_out && seen_q
        |-> gap_q == LP_DIV - 1) else $error("capped cpu tick spacing wrong");
    a_schmitt_off: assert property (sys_reset_out |->
        !schmitt_en_out ##1 !schmitt_en_out)
        else $error("schmitt enabled around reset");
    a_backup_sel: assert property (!$past(reset_in) |-> backup_from_main_out ==
        $past(main_supply_valid_in && backup_supply_valid_in))
        else $error("backup domain source wrong");
    a_charge_gate: assert property (charge_en_out |-> $past(main_supply_valid_in))
        else $error("charger on without valid main supply");
    a_pull_hold: assert property (sb_w && $past(sb_w) |-> $stable(pull_out))
        else $error("pull choice moved in standby");
endmodule

// File: dv/lpmc_ctrl_tb.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module lpmc_ctrl_tb;
    localparam int LPD = 4;
    localparam int WRC = 3;
    logic core_clk_in = 0, reset_in = 1, supply_good_in = 1, mode_req_in = 0, cpu_halted_in = 0;
    logic irq_in = 0, periph_wake_in = 0, periph_osc_req_in = 0, rtc_keep_in = 0;
    logic wake_pin_in = 0, wake_pin_fall_in = 0, internal_reset_src_in = 0, charge_req_in = 0;
    logic main_supply_valid_in = 1, backup_supply_valid_in = 1;
    lpmc_pkg::lpmc_sel_e mode_sel_in = lpmc_pkg::SEL_RUN;
    lpmc_pkg::lpmc_wake_s standby_wake_in = '0;
    logic [lpmc_pkg::PULL_W-1:0] pull_cfg_in = '0, pull_out, pc;
    lpmc_pkg::lpmc_mode_e mode_out;
    lpmc_pkg::lpmc_pwr_s pwr_out;
    logic cpu_clk_en_out, sys_reset_out, schmitt_en_out, reset_pin_pullup_en_out;
    logic backup_from_main_out, charge_en_out;
    logic [31:0] seed = 32'h0000_0d20;
    int err_total = 0, compares = 0, e = 0, p, k = 0, n;
    // 250 MHz core clock
    always #2 core_clk_in = ~core_clk_in;
    // Short divider and reboot pulse keep the run brief
    lpmc_ctrl #(.LP_DIV(LPD), .WAKE_RST_CYCLES(WRC)) dut (.core_clk_in, .reset_in,
        .supply_good_in, .mode_sel_in, .mode_req_in, .cpu_halted_in, .irq_in, .periph_wake_in,
        .periph_osc_req_in, .rtc_keep_in, .standby_wake_in, .wake_pin_in, .wake_pin_fall_in,
        .internal_reset_src_in, .pull_cfg_in, .main_supply_valid_in, .backup_supply_valid_in,
        .charge_req_in, .mode_out, .pwr_out, .cpu_clk_en_out, .sys_reset_out, .schmitt_en_out,
        .reset_pin_pullup_en_out, .pull_out, .backup_from_main_out, .charge_en_out);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Mode model: only run modes accept requests; halt-gated entries; SLEEP adds one
    function automatic int nxt(input int c, input int s, input bit h);
        if (c != 0 && c != 2) return c;
        case (s)
            0: return 0;
            2: return 2;
            1: return h ? c + 1 : c;
            3, 4, 5: return h ? s + 1 : c;
            default: return c;
        endcase
    endfunction
    task end_of_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task req(input int s, input bit h);
        @(posedge core_clk_in);
        mode_sel_in <= lpmc_pkg::lpmc_sel_e'(s[2:0]);
        mode_req_in <= 1;
        cpu_halted_in <= h;
        e = nxt(e, s, h);
        @(posedge core_clk_in);
        mode_req_in <= 0;
        cpu_halted_in <= 0;
        @(negedge core_clk_in);
        `CHK(mode_out, 3'(e))
    endtask
    // Sleep wakes on interrupt only; stop picks one of the two wake inputs from seed bit 0
    task wake_run;
        @(negedge core_clk_in);
        if (e > 3) `CHK(pwr_out.rtc_en, rtc_keep_in)
        @(posedge core_clk_in);
        irq_in <= e < 4 || seed[0];
        periph_wake_in <= !(e < 4 || seed[0]);
        @(posedge core_clk_in);
        irq_in <= 0;
        periph_wake_in <= 0;
        @(negedge core_clk_in);
        e = p;
        `CHK(mode_out, 3'(e))
    endtask
    // A reset-pin wake is tried first without main supply, where it must be ignored
    task wake_sb;
        @(posedge core_clk_in);
        pull_cfg_in <= ~pc;
        main_supply_valid_in <= 0;
        standby_wake_in <= 6'h20;
        repeat (3) @(posedge core_clk_in);
        @(negedge core_clk_in);
        `CHK({mode_out, pull_out, charge_en_out, backup_from_main_out},
            {3'h6, pc, 2'b00})
        @(posedge core_clk_in);
        standby_wake_in <= '0;
        main_supply_valid_in <= 1;
        rtc_keep_in <= 1;
        wake_pin_fall_in <= seed[1];
        wake_pin_in <= seed[1];
        @(posedge core_clk_in);
        if (k < 6) standby_wake_in <= 6'(1 << k);
        else wake_pin_in <= !wake_pin_fall_in;
        @(posedge core_clk_in);
        standby_wake_in <= '0;
        // Look only at settled outputs, never in the edge that launches them
        @(negedge core_clk_in);
        n = 0;
        while (mode_out !== lpmc_pkg::M_REBOOT && n < 6) begin
            @(negedge core_clk_in);
            n++;
        end
        `CHK(mode_out, 3'h7)
        n = 0;
        while (mode_out === lpmc_pkg::M_REBOOT && n < 40) begin
            `CHK(sys_reset_out, 1'b1)
            @(negedge core_clk_in);
            n++;
        end
        `CHK(n, WRC)
        `CHK(mode_out, 3'h0)
        e = 0;
        k = (k + 1) % 7;
    endtask
    // Main sequence: every code from both run modes unhalted, then halted from the mode that request leaves
    initial begin
        repeat (12) @(posedge core_clk_in);
        reset_in <= 0;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        `CHK({mode_out, sys_reset_out, cpu_clk_en_out, schmitt_en_out}, 6'b000_010)
        @(negedge core_clk_in);
        `CHK(schmitt_en_out, 1'b1)
        for (int b = 0; b < 8; b++) begin
            for (int c = 0; c < 8; c++) begin
                @(posedge core_clk_in);
                pc = rnd();
                pull_cfg_in <= pc;
                {rtc_keep_in, periph_osc_req_in, backup_supply_valid_in, charge_req_in} <=
                    4'(rnd());
                if (b[0]) req(2, 0);
                req(c, 0);
                p = e;
                req(c, 1);
                if (e inside {1, 3, 4, 5}) wake_run();
                else if (e == 6) wake_sb();
                if (e == 2) req(0, 0);
            end
        end
        req(2, 0);
        @(posedge core_clk_in);
        supply_good_in <= 0;
        internal_reset_src_in <= 1;
        repeat (3) @(posedge core_clk_in);
        @(negedge core_clk_in);
        `CHK({sys_reset_out, reset_pin_pullup_en_out, mode_out}, 5'b10_000)
        @(posedge core_clk_in);
        supply_good_in <= 1;
        internal_reset_src_in <= 0;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        `CHK({sys_reset_out, mode_out}, 4'b0_000)
        end_of_test();
    end
    // Watchdog sized well above the roughly 600 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk_in);
        err_total++;
        end_of_test();
    end
endmodule
bind lpmc_ctrl lpmc_ctrl_props #(.LP_DIV(LP_DIV)) u_props (.core_clk_in, .reset_in,
    .supply_good_in, .periph_osc_req_in, .main_supply_valid_in, .backup_supply_valid_in,
    .mode_out, .pwr_out, .cpu_clk_en_out, .sys_reset_out, .schmitt_en_out, .pull_out,
    .backup_from_main_out, .charge_en_out);
